// ==== rtl/cpu_status_core_control.sv ====
// Holds: processor status byte, core control register and their AXI4-Lite slave.
// Assumes: core inputs are synchronous to i_clk; one AXI master.
//
// What this block does
// - Status bits 7:5 hold the 3-bit priority, 111 is level 7, user irqs off.
// - Effective 4-bit level is core control bit 3 above status bits 7:5.
// - With the priority MSB set, level is 8 to 15 and user irqs are blocked.
// - Software cannot write status bits 7:5 while nesting disable is set.
// - Status bit 4 follows the single-instruction loop busy state.
// - Status bit 3 shows whether the last flag-affecting result was negative.
// - Status bit 2 shows signed two's complement overflow of the last result.
// - Sticky zero bit stays set until a zero-affecting op gives non-zero.
// - Status bit 0 shows carry out of the result MSB.
// - Status writes change clip stickies directly or by clearing the combined bit.
// - The early-exit bit always reads back as zero.
// - Core control bit 1 selects biased or convergent rounding.
// - Core control bit 0 selects integer or fractional DSP multiply.
// - Frame active lets frame and stack pointers reach the full 64 KB range.
`timescale 1ns/1ns
module cpu_status_core_control import cpu_status_pkg::*; (
	input wire logic i_clk, // Core clock, 100 MHz
	input wire logic i_srst, // Synchronous reset, active high
	input wire logic i_ce, // Clock enable, freezes all state when low
	input wire logic [7:0] i_awaddr, // AXI write address
	input wire logic i_awvalid, // AXI write address valid
	output logic o_awready, // AXI write address ready
	input wire logic [31:0] i_wdata, // AXI write data
	input wire logic [3:0] i_wstrb, // AXI write strobes
	input wire logic i_wvalid, // AXI write data valid
	output logic o_wready, // AXI write data ready
	output logic [1:0] o_bresp, // AXI write response
	output logic o_bvalid, // AXI write response valid
	input wire logic i_bready, // AXI write response ready
	input wire logic [7:0] i_araddr, // AXI read address
	input wire logic i_arvalid, // AXI read address valid
	output logic o_arready, // AXI read address ready
	output logic [31:0] o_rdata, // AXI read data
	output logic [1:0] o_rresp, // AXI read response
	output logic o_rvalid, // AXI read data valid
	input wire logic i_rready, // AXI read data ready
	input wire alu_op_s i_alu, // ALU flag report
	input wire logic i_single_loop_busy, // Single-instruction loop running
	input wire logic [2:0] i_loop_depth, // Active hardware loop count
	input wire logic i_frame_active, // Stack frame active
	input wire logic i_prio_load, // Core loads priority low bits
	input wire logic [2:0] i_prio_value, // Value for the core load
	input wire logic i_prio_msb_set, // Core sets the priority MSB
	input wire logic i_clip_a, // Accumulator A saturated
	input wire logic i_clip_b, // Accumulator B saturated
	output logic [3:0] o_eff_priority, // Effective priority level
	output logic o_user_irq_block, // User interrupts blocked
	output dsp_cfg_s o_dsp_cfg, // DSP engine options
	output logic o_loop_early_exit, // Pulse: end loop after this pass
	output logic o_frame_full_range, // Pointers ignore data page
	output logic o_irq // Level interrupt
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d, rd_cfg_q, rd_cfg_d, exit_d;
	logic [7:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d, rdata_d;
	logic [3:0] wstrb_q, wstrb_d, nvzc_q, nvzc_d, nvzc_alu, eff_d;
	logic [1:0] bresp_d, rresp_d;
	logic bvalid_d, rvalid_d, awready_d, wready_d, arready_d, block_d, irq_d;
	logic loop_busy_q, loop_busy_d, frame_q, frame_d, nest_dis_q, nest_dis_d;
	logic clip_a_q, clip_a_d, clip_b_q, clip_b_d, prio_msb_q, prio_msb_d;
	logic [2:0] prio_lo_q, prio_lo_d, depth_q, depth_d, mask_q, mask_d;
	dsp_cfg_s cfg_q, cfg_d;
	logic [N_EVENTS-1:0] ev_set, ev_clr, ev_stat;
	// Access decode
	logic do_wr, do_rd, wr_flags, wr_cfg, wr_ic, wr_stat, wr_mask, wr_ok;
	logic [15:0] wmask, wv, flags_rd, cfg_rd;

	// ----------------------------------------------------------------
	// Flag evaluation and event stickies
	// ----------------------------------------------------------------
	alu_flag_eval u_flags (
		.i_op(i_alu),
		.i_flags(nvzc_q),
		.o_flags(nvzc_alu)
	);

	sticky_bits #(.W(N_EVENTS)) u_events (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_ce(i_ce),
		.i_set(ev_set),
		.i_clr(ev_clr),
		.o_q(ev_stat)
	);

	always_comb begin
		ev_set[EV_WRAP] = i_alu.valid && i_alu.upd_nvc && nvzc_alu[2];
		ev_set[EV_CLIP_A] = i_clip_a;
		ev_set[EV_CLIP_B] = i_clip_b;
		ev_clr = wr_stat ? (wv[N_EVENTS-1:0] & wmask[N_EVENTS-1:0]) : '0;
	end

	// ----------------------------------------------------------------
	// Read views
	// ----------------------------------------------------------------
	always_comb begin
		flags_rd = 16'h0000;
		flags_rd[FL_CARRY] = nvzc_q[0];
		flags_rd[FL_ZERO] = nvzc_q[1];
		flags_rd[FL_WRAP] = nvzc_q[2];
		flags_rd[FL_NEG] = nvzc_q[3];
		flags_rd[FL_LOOP] = loop_busy_q;
		flags_rd[FL_PRIO_LO +: 3] = prio_lo_q;
		flags_rd[FL_EITHER] = clip_a_q | clip_b_q;
		flags_rd[FL_CLIP_B] = clip_b_q;
		flags_rd[FL_CLIP_A] = clip_a_q;
		cfg_rd = 16'h0000;
		cfg_rd[CF_MUL_INT] = cfg_q.mul_integer;
		cfg_rd[CF_ROUND] = cfg_q.round_biased;
		cfg_rd[CF_FRAME] = frame_q;
		cfg_rd[CF_PRIO_MSB] = prio_msb_q;
		cfg_rd[CF_WIDE_CLIP] = cfg_q.wide_clip_select;
		cfg_rd[CF_STORE_CLIP] = cfg_q.store_clip_enable;
		cfg_rd[CF_CLIP_B] = cfg_q.acc_b_clip_enable;
		cfg_rd[CF_CLIP_A] = cfg_q.acc_a_clip_enable;
		cfg_rd[CF_DEPTH +: 3] = depth_q;
		cfg_rd[CF_EXIT] = 1'b0;
		cfg_rd[CF_SIGN_SEL +: 2] = cfg_q.mul_sign_select;
		cfg_rd[CF_VAR] = cfg_q.var_latency;
	end

	// ----------------------------------------------------------------
	// Bus slave and register next state
	// ----------------------------------------------------------------
	always_comb begin
		aw_hold_d = aw_hold_q;
		awaddr_d = awaddr_q;
		w_hold_d = w_hold_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = o_bvalid && !i_bready;
		bresp_d = o_bresp;
		rvalid_d = o_rvalid && !i_rready;
		rresp_d = o_rresp;
		rdata_d = o_rdata;
		rd_cfg_d = rd_cfg_q;
		if (o_awready && i_awvalid) begin
			aw_hold_d = 1'b1;
			awaddr_d = i_awaddr;
		end
		if (o_wready && i_wvalid) begin
			w_hold_d = 1'b1;
			wdata_d = i_wdata;
			wstrb_d = i_wstrb;
		end
		do_wr = aw_hold_q && w_hold_q && !o_bvalid;
		wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
		wv = wdata_q[15:0];
		wr_flags = do_wr && (awaddr_q == OFS_FLAGS);
		wr_cfg = do_wr && (awaddr_q == OFS_CFG);
		wr_ic = do_wr && (awaddr_q == OFS_INTCTL);
		wr_stat = do_wr && (awaddr_q == OFS_IRQ_STAT);
		wr_mask = do_wr && (awaddr_q == OFS_IRQ_MASK);
		wr_ok = wr_flags || wr_cfg || wr_ic || wr_stat || wr_mask || (awaddr_q == OFS_PRIO);
		if (do_wr) begin
			aw_hold_d = 1'b0;
			w_hold_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		do_rd = o_arready && i_arvalid;
		if (do_rd) begin
			rvalid_d = 1'b1;
			rresp_d = RESP_OKAY;
			rd_cfg_d = (i_araddr == OFS_CFG);
			case (i_araddr)
				OFS_FLAGS: rdata_d = {16'h0000, flags_rd};
				OFS_CFG: rdata_d = {16'h0000, cfg_rd};
				OFS_INTCTL: rdata_d = {16'h0000, nest_dis_q, 15'h0000};
				OFS_IRQ_STAT: rdata_d = {29'h0000000, ev_stat};
				OFS_IRQ_MASK: rdata_d = {29'h0000000, mask_q};
				OFS_PRIO: rdata_d = {27'h0000000, o_user_irq_block, o_eff_priority};
				default: begin
					rdata_d = 32'h00000000;
					rresp_d = RESP_SLVERR;
				end
			endcase
		end
		awready_d = !aw_hold_d && !bvalid_d;
		wready_d = !w_hold_d && !bvalid_d;
		arready_d = !rvalid_d;
		// Priority low bits: core load first, then software unless locked
		prio_lo_d = prio_lo_q;
		if (i_prio_load) begin
			prio_lo_d = i_prio_value;
		end else if (wr_flags && wmask[0] && !nest_dis_q) begin
			prio_lo_d = wv[FL_PRIO_LO +: 3];
		end
		loop_busy_d = i_single_loop_busy;
		// Software write, overruled by an ALU report in the same cycle
		nvzc_d = nvzc_q;
		if (wr_flags && wmask[0]) begin
			nvzc_d = {wv[FL_NEG], wv[FL_WRAP], wv[FL_ZERO], wv[FL_CARRY]};
		end
		if (i_alu.valid) begin
			nvzc_d = nvzc_alu;
		end
		// Clip stickies: direct write, or clear via the combined bit
		clip_a_d = clip_a_q;
		clip_b_d = clip_b_q;
		if (wr_flags && wmask[8]) begin
			if ((clip_a_q | clip_b_q) && !wv[FL_EITHER]) begin
				clip_a_d = 1'b0;
				clip_b_d = 1'b0;
			end else begin
				clip_a_d = wv[FL_CLIP_A];
				clip_b_d = wv[FL_CLIP_B];
			end
		end
		clip_a_d = clip_a_d | i_clip_a;
		clip_b_d = clip_b_d | i_clip_b;
		// Priority MSB: software may only clear, core set wins
		prio_msb_d = prio_msb_q;
		if (wr_cfg && wmask[0] && !wv[CF_PRIO_MSB]) begin
			prio_msb_d = 1'b0;
		end
		prio_msb_d = prio_msb_d | i_prio_msb_set;
		cfg_d = cfg_q;
		exit_d = 1'b0;
		if (wr_cfg && wmask[0]) begin
			cfg_d.mul_integer = wv[CF_MUL_INT];
			cfg_d.round_biased = wv[CF_ROUND];
			cfg_d.wide_clip_select = wv[CF_WIDE_CLIP];
			cfg_d.store_clip_enable = wv[CF_STORE_CLIP];
			cfg_d.acc_b_clip_enable = wv[CF_CLIP_B];
			cfg_d.acc_a_clip_enable = wv[CF_CLIP_A];
		end
		if (wr_cfg && wmask[8]) begin
			cfg_d.mul_sign_select = wv[CF_SIGN_SEL +: 2];
			cfg_d.var_latency = wv[CF_VAR];
			exit_d = wv[CF_EXIT];
		end
		depth_d = i_loop_depth;
		frame_d = i_frame_active;
		nest_dis_d = nest_dis_q;
		if (wr_ic && wmask[8]) begin
			nest_dis_d = wv[IC_NEST_DIS];
		end
		mask_d = mask_q;
		if (wr_mask && wmask[0]) begin
			mask_d = wv[N_EVENTS-1:0];
		end
		eff_d = {prio_msb_d, prio_lo_d};
		block_d = (eff_d >= LEVEL_BLOCK);
		irq_d = |((ev_stat & ~ev_clr | ev_set) & mask_d);
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			o_awready <= 1'b0;
			o_wready <= 1'b0;
			o_arready <= 1'b0;
			o_bvalid <= 1'b0;
			o_bresp <= RESP_OKAY;
			o_rvalid <= 1'b0;
			o_rresp <= RESP_OKAY;
			o_rdata <= 32'h00000000;
			rd_cfg_q <= 1'b0;
			prio_lo_q <= RST_PRIO_LO;
			loop_busy_q <= 1'b0;
			nvzc_q <= 4'h0;
			clip_a_q <= 1'b0;
			clip_b_q <= 1'b0;
			prio_msb_q <= 1'b0;
			cfg_q <= '{store_clip_enable: RST_STORE_CLIP, default: '0};
			depth_q <= 3'h0;
			frame_q <= 1'b0;
			nest_dis_q <= 1'b0;
			mask_q <= RST_MASK;
			o_eff_priority <= 4'h0;
			o_user_irq_block <= 1'b0;
			o_dsp_cfg <= '{store_clip_enable: RST_STORE_CLIP, default: '0};
			o_loop_early_exit <= 1'b0;
			o_frame_full_range <= 1'b0;
			o_irq <= 1'b0;
		end else if (i_ce) begin
			aw_hold_q <= aw_hold_d;
			w_hold_q <= w_hold_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			o_awready <= awready_d;
			o_wready <= wready_d;
			o_arready <= arready_d;
			o_bvalid <= bvalid_d;
			o_bresp <= bresp_d;
			o_rvalid <= rvalid_d;
			o_rresp <= rresp_d;
			o_rdata <= rdata_d;
			rd_cfg_q <= rd_cfg_d;
			prio_lo_q <= prio_lo_d;
			loop_busy_q <= loop_busy_d;
			nvzc_q <= nvzc_d;
			clip_a_q <= clip_a_d;
			clip_b_q <= clip_b_d;
			prio_msb_q <= prio_msb_d;
			cfg_q <= cfg_d;
			depth_q <= depth_d;
			frame_q <= frame_d;
			nest_dis_q <= nest_dis_d;
			mask_q <= mask_d;
			o_eff_priority <= eff_d;
			o_user_irq_block <= block_d;
			o_dsp_cfg <= cfg_d;
			o_loop_early_exit <= exit_d;
			o_frame_full_range <= frame_d;
			o_irq <= irq_d;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence wr_cfg_exit_s;
		i_ce && wr_cfg && wmask[8] && wv[CF_EXIT];
	endsequence
	sequence exit_pulse_s;
		o_loop_early_exit ##1 (!o_loop_early_exit || !$past(i_ce) || $past(exit_d));
	endsequence
	eff_level_a: assert property (@(posedge i_clk) disable iff (i_srst)
		o_eff_priority == {prio_msb_q, prio_lo_q})
		else $error("effective level differs from its fields");
	user_block_a: assert property (@(posedge i_clk) disable iff (i_srst)
		o_user_irq_block == (prio_msb_q || (prio_lo_q == 3'h7)))
		else $error("user interrupt block wrong for level");
	prio_lock_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(i_ce && wr_flags && nest_dis_q && !i_prio_load) |=> $stable(prio_lo_q))
		else $error("locked priority bits changed by software");
	loop_busy_a: assert property (@(posedge i_clk) disable iff (i_srst)
		i_ce |=> (flags_rd[FL_LOOP] == $past(i_single_loop_busy)))
		else $error("loop busy bit does not follow the loop");
	neg_flag_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(i_ce && i_alu.valid && i_alu.upd_nvc) |=> (nvzc_q[3] == $past(i_alu.result[15])))
		else $error("negative flag wrong");
	carry_flag_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(i_ce && i_alu.valid && i_alu.upd_nvc) |=> (nvzc_q[0] == $past(i_alu.carry_out)))
		else $error("carry flag wrong");
	zero_keep_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(i_ce && i_alu.valid && i_alu.upd_z && (i_alu.result != 16'h0000)) |=> !nvzc_q[1])
		else $error("zero flag not cleared by non-zero result");
	clip_clear_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(i_ce && wr_flags && wmask[8] && (clip_a_q || clip_b_q) && !wv[FL_EITHER]
			&& !i_clip_a && !i_clip_b) |=> (!clip_a_q && !clip_b_q))
		else $error("combined clear left a clip sticky set");
	early_exit_a: assert property (@(posedge i_clk) disable iff (i_srst)
		wr_cfg_exit_s |=> exit_pulse_s)
		else $error("early exit pulse missing or stretched");
	exit_read_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(o_rvalid && rd_cfg_q) |-> !o_rdata[CF_EXIT])
		else $error("early exit bit read back non-zero");
	round_mode_a: assert property (@(posedge i_clk) disable iff (i_srst)
		(i_ce && wr_cfg && wmask[0]) |=> (o_dsp_cfg.round_biased == $past(wv[CF_ROUND])))
		else $error("rounding select not taken");
endmodule

// ==== rtl/cpu_status_pkg.sv ====
// Package: register map, field positions, reset values and carriers
// of the status/core control bank.
// Assumes a 32-bit AXI4-Lite register bus with 8-bit byte addresses.
package cpu_status_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_FLAGS = 8'h00;
	localparam logic [7:0] OFS_CFG = 8'h04;
	localparam logic [7:0] OFS_INTCTL = 8'h08;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
	localparam logic [7:0] OFS_PRIO = 8'h14;

	// ----------------------------------------------------------------
	// cpu_flags_register fields
	// ----------------------------------------------------------------
	localparam int FL_CARRY = 0;
	localparam int FL_ZERO = 1;
	localparam int FL_WRAP = 2;
	localparam int FL_NEG = 3;
	localparam int FL_LOOP = 4;
	localparam int FL_PRIO_LO = 5;
	localparam int FL_EITHER = 10;
	localparam int FL_CLIP_B = 12;
	localparam int FL_CLIP_A = 13;

	// ----------------------------------------------------------------
	// core_config_register fields
	// ----------------------------------------------------------------
	localparam int CF_MUL_INT = 0;
	localparam int CF_ROUND = 1;
	localparam int CF_FRAME = 2;
	localparam int CF_PRIO_MSB = 3;
	localparam int CF_WIDE_CLIP = 4;
	localparam int CF_STORE_CLIP = 5;
	localparam int CF_CLIP_B = 6;
	localparam int CF_CLIP_A = 7;
	localparam int CF_DEPTH = 8;
	localparam int CF_EXIT = 11;
	localparam int CF_SIGN_SEL = 12;
	localparam int CF_VAR = 15;

	// interrupt_control_one field
	localparam int IC_NEST_DIS = 15;

	// ----------------------------------------------------------------
	// Reset values and constants
	// ----------------------------------------------------------------
	localparam logic RST_STORE_CLIP = 1'b1;
	localparam logic [2:0] RST_PRIO_LO = 3'h0;
	localparam logic [2:0] RST_MASK = 3'h0;
	localparam logic [3:0] LEVEL_BLOCK = 4'h7;
	localparam int N_EVENTS = 3;
	localparam int EV_WRAP = 0;
	localparam int EV_CLIP_A = 1;
	localparam int EV_CLIP_B = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic upd_nvc;
		logic upd_z;
		logic z_sticky;
		logic is_sub;
		logic opa_msb;
		logic opb_msb;
		logic carry_out;
		logic [15:0] result;
	} alu_op_s;

	typedef struct packed {
		logic var_latency;
		logic [1:0] mul_sign_select;
		logic acc_a_clip_enable;
		logic acc_b_clip_enable;
		logic store_clip_enable;
		logic wide_clip_select;
		logic round_biased;
		logic mul_integer;
	} dsp_cfg_s;

endpackage

// ==== rtl/sticky_bits.sv ====
// Holds: a row of sticky event bits, set by hardware, cleared by software.
// Assumes: set and clear are single-cycle strobes on i_clk.
`timescale 1ns/1ns
module sticky_bits #(
	parameter int W = 1
) (
	input wire logic i_clk, // Core clock
	input wire logic i_srst, // Synchronous reset
	input wire logic i_ce, // Clock enable
	input wire logic [W-1:0] i_set, // Event strobes
	input wire logic [W-1:0] i_clr, // Clear strobes
	output logic [W-1:0] o_q // Sticky bits
);
	logic [W-1:0] q_d;

	// Set beats clear in the same cycle
	always_comb begin
		q_d = (o_q & ~i_clr) | i_set;
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_q <= '0;
		end else if (i_ce) begin
			o_q <= q_d;
		end
	end
endmodule

// ==== rtl/alu_flag_eval.sv ====
// Holds: next values of the negative, signed wrap, zero and carry flags.
// Assumes: the datapath presents one flag-affecting result per cycle.
`timescale 1ns/1ns
module alu_flag_eval import cpu_status_pkg::*; (
	input wire alu_op_s i_op, // ALU result report
	input wire logic [3:0] i_flags, // Current {n, ov, z, c}
	output logic [3:0] o_flags // Next {n, ov, z, c}
);
	logic res_msb;
	logic res_zero;
	logic wrap;

	always_comb begin
		res_msb = i_op.result[15];
		res_zero = (i_op.result == 16'h0000);
		// Sign flips wrongly when operand signs allow no such change
		if (i_op.is_sub) begin
			wrap = (i_op.opa_msb != i_op.opb_msb) && (res_msb != i_op.opa_msb);
		end else begin
			wrap = (i_op.opa_msb == i_op.opb_msb) && (res_msb != i_op.opa_msb);
		end
		o_flags = i_flags;
		if (i_op.valid && i_op.upd_nvc) begin
			o_flags[3] = res_msb;
			o_flags[2] = wrap;
			o_flags[0] = i_op.carry_out;
		end
		if (i_op.valid && i_op.upd_z) begin
			// Sticky form only ever clears on a non-zero result
			o_flags[1] = i_op.z_sticky ? (i_flags[1] & res_zero) : res_zero;
		end
	end
endmodule

// ==== test/cpu_status_core_control_tb.sv ====
// Self-checking bench for the status byte and core control register bank.
// Assumes an AXI4-Lite slave that answers in its own time; one clock, no partner model.
`timescale 1ns/1ns
module cpu_status_core_control_tb import cpu_status_pkg::*;;
	logic i_clk = 1'b0, i_srst = 1'b1, i_ce = 1'b1;
	logic [7:0] i_awaddr = '0, i_araddr = '0;
	logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
	logic [31:0] i_wdata = '0;
	logic [3:0] i_wstrb = '0;
	alu_op_s i_alu = '0;
	logic i_single_loop_busy = 1'b0, i_frame_active = 1'b0, i_prio_load = 1'b0;
	logic i_prio_msb_set = 1'b0, i_clip_a = 1'b0, i_clip_b = 1'b0;
	logic [2:0] i_loop_depth = '0, i_prio_value = '0, dep;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_user_irq_block;
	logic o_loop_early_exit, o_frame_full_range, o_irq, ov, z;
	logic [1:0] o_bresp, o_rresp, last_resp;
	logic [31:0] o_rdata, last_data;
	logic [3:0] o_eff_priority, exp_f;
	dsp_cfg_s o_dsp_cfg;
	alu_op_s op;
	int failures = 0, cmp_count = 0, cyc = 0, exits = 0;

	cpu_status_core_control u_cpu_status_core_control (
		.i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce), .i_awaddr(i_awaddr),
		.i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
		.i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
		.i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
		.o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
		.i_rready(i_rready), .i_alu(i_alu), .i_single_loop_busy(i_single_loop_busy),
		.i_loop_depth(i_loop_depth), .i_frame_active(i_frame_active),
		.i_prio_load(i_prio_load), .i_prio_value(i_prio_value),
		.i_prio_msb_set(i_prio_msb_set), .i_clip_a(i_clip_a), .i_clip_b(i_clip_b),
		.o_eff_priority(o_eff_priority), .o_user_irq_block(o_user_irq_block),
		.o_dsp_cfg(o_dsp_cfg), .o_loop_early_exit(o_loop_early_exit),
		.o_frame_full_range(o_frame_full_range), .o_irq(o_irq)
	);

	always #5 i_clk = ~i_clk;

	always @(posedge i_clk) begin
		if (o_loop_early_exit === 1'b1)
			exits <= exits + 1;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			$display("[ERR] %0t timeout", $time);
			failures++;
			report_and_stop();
		end
	end

	// ----------------------------------------------------------------
	// Bus and compare tasks
	// ----------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge i_clk);
		i_awaddr <= a;
		i_wdata <= d;
		i_wstrb <= s;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		do begin
			@(posedge i_clk);
			if (i_awvalid && o_awready === 1'b1)
				i_awvalid <= 1'b0;
			if (i_wvalid && o_wready === 1'b1)
				i_wvalid <= 1'b0;
		end while (o_bvalid !== 1'b1);
		last_resp = o_bresp;
		i_bready <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge i_clk);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		do begin
			@(posedge i_clk);
			if (i_arvalid && o_arready === 1'b1)
				i_arvalid <= 1'b0;
		end while (o_rvalid !== 1'b1);
		last_data = o_rdata;
		last_resp = o_rresp;
		i_rready <= 1'b0;
		chk(last_data, e);
		chk({30'h0, last_resp}, {30'h0, r});
	endtask

	task automatic prio_chk(input logic [4:0] e);
		tick(2);
		chk({27'h0, o_user_irq_block, o_eff_priority}, {27'h0, e});
	endtask

	task report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h1963));
		tick(16);
		i_srst <= 1'b0;
		tick(2);
		rchk(OFS_FLAGS, 32'h0, RESP_OKAY);
		rchk(OFS_CFG, 32'h20, RESP_OKAY);
		chk({23'h0, o_dsp_cfg}, 32'h8);
		wr(OFS_FLAGS, 32'he0, 4'h3);
		prio_chk(5'h17);
		rchk(OFS_PRIO, 32'h17, RESP_OKAY);
		wr(OFS_FLAGS, 32'h60, 4'h3);
		prio_chk(5'h03);
		i_prio_msb_set <= 1'b1;
		tick(1);
		i_prio_msb_set <= 1'b0;
		prio_chk(5'h1b);
		rchk(OFS_CFG, 32'h28, RESP_OKAY);
		wr(OFS_CFG, 32'h20, 4'h3);
		prio_chk(5'h03);
		wr(OFS_INTCTL, 32'h8000, 4'h3);
		rchk(OFS_INTCTL, 32'h8000, RESP_OKAY);
		wr(OFS_FLAGS, 32'he0, 4'h3);
		rchk(OFS_FLAGS, 32'h60, RESP_OKAY);
		i_prio_value <= 3'h5;
		i_prio_load <= 1'b1;
		tick(1);
		i_prio_load <= 1'b0;
		prio_chk(5'h05);
		wr(OFS_INTCTL, 32'h0, 4'h3);
		wr(OFS_FLAGS, 32'h0, 4'h3);
		rchk(OFS_FLAGS, 32'h0, RESP_OKAY);
		i_single_loop_busy <= 1'b1;
		tick(2);
		rchk(OFS_FLAGS, 32'h10, RESP_OKAY);
		i_single_loop_busy <= 1'b0;
		tick(2);
		rchk(OFS_FLAGS, 32'h0, RESP_OKAY);
		// Clip stickies, interrupt raise, clear and mask
		wr(OFS_IRQ_MASK, 32'h2, 4'hf);
		i_clip_a <= 1'b1;
		tick(1);
		i_clip_a <= 1'b0;
		tick(2);
		chk({31'h0, o_irq}, 32'h1);
		rchk(OFS_FLAGS, 32'h2400, RESP_OKAY);
		wr(OFS_FLAGS, 32'h0, 4'h2);
		rchk(OFS_FLAGS, 32'h0, RESP_OKAY);
		wr(OFS_IRQ_STAT, 32'h7, 4'hf);
		i_clip_b <= 1'b1;
		tick(1);
		i_clip_b <= 1'b0;
		tick(2);
		chk({31'h0, o_irq}, 32'h0);
		rchk(OFS_IRQ_STAT, 32'h4, RESP_OKAY);
		rchk(OFS_FLAGS, 32'h1400, RESP_OKAY);
		wr(OFS_FLAGS, 32'h3400, 4'h2);
		rchk(OFS_FLAGS, 32'h3400, RESP_OKAY);
		wr(OFS_FLAGS, 32'h0, 4'h2);
		rchk(OFS_FLAGS, 32'h0, RESP_OKAY);
		// Core control options, depth and early exit
		dep = 3'($urandom);
		i_loop_depth <= dep;
		i_frame_active <= 1'b1;
		wr(OFS_CFG, 32'ha8f3, 4'h3);
		tick(2);
		chk(32'(exits), 32'h1);
		wr(OFS_CFG, 32'ha0f3, 4'h3);
		tick(2);
		chk(32'(exits), 32'h1);
		rchk(OFS_CFG, {16'h0, 5'h14, dep, 8'hf7}, RESP_OKAY);
		chk({30'h0, o_frame_full_range, o_dsp_cfg.store_clip_enable}, 32'h3);
		chk({23'h0, o_dsp_cfg}, 32'h1bf);
		// Clock enable low freezes the sampled frame state
		i_ce <= 1'b0;
		i_frame_active <= 1'b0;
		tick(3);
		chk({31'h0, o_frame_full_range}, 32'h1);
		i_ce <= 1'b1;
		tick(2);
		chk({31'h0, o_frame_full_range}, 32'h0);
		wr(OFS_CFG, 32'h0020, 4'h3);
		tick(2);
		chk({30'h0, o_dsp_cfg.round_biased, o_dsp_cfg.mul_integer}, 32'h0);
		// Random ALU reports against the flag model
		exp_f = 4'h0;
		for (int k = 0; k < 24; k++) begin
			op = alu_op_s'(24'($urandom));
			op.valid = 1'b1;
			if (k % 3 == 0)
				op.result = 16'h0;
			if (op.is_sub)
				ov = (op.opa_msb != op.opb_msb) && (op.result[15] != op.opa_msb);
			else
				ov = (op.opa_msb == op.opb_msb) && (op.result[15] != op.opa_msb);
			z = (op.result == 16'h0);
			if (op.upd_nvc)
				exp_f = {op.result[15], ov, exp_f[1], op.carry_out};
			if (op.upd_z)
				exp_f[1] = op.z_sticky ? (exp_f[1] & z) : z;
			i_alu <= op;
			tick(1);
			i_alu <= '0;
			rchk(OFS_FLAGS, {28'h0, exp_f}, RESP_OKAY);
		end
		rchk(8'h18, 32'h0, RESP_SLVERR);
		wr(8'h1c, 32'hffff, 4'hf);
		chk({30'h0, last_resp}, {30'h0, RESP_SLVERR});
		report_and_stop();
	end
endmodule
